// ### core/erc_pkg.sv
// Purpose: Constants and types for the reset and top-level control block
// Assumes: Register byte address is four times the register index
// Notes: Index 48 hex holds the sector mark control register
package erc_pkg;
  localparam int DATA_W = 32;
  localparam int IDX_W = 8;
  localparam logic [7:0] IDX_CTL1 = 8'h10;
  localparam logic [7:0] IDX_CFG3 = 8'h12;
  localparam logic [7:0] IDX_XFER = 8'h1A;
  localparam logic [7:0] IDX_IEN0 = 8'h20;
  localparam logic [7:0] IDX_IEN1 = 8'h21;
  localparam logic [7:0] IDX_IST0 = 8'h22;
  localparam logic [7:0] IDX_IST1 = 8'h23;
  localparam logic [7:0] IDX_LIMIT = 8'h27;
  localparam logic [7:0] IDX_PLL = 8'h2C;
  localparam logic [7:0] IDX_LATCH0 = 8'h30;
  localparam logic [7:0] IDX_GPO = 8'h39;
  localparam logic [7:0] IDX_LATCH1 = 8'h3F;
  localparam logic [7:0] IDX_SMC = 8'h48;
  localparam int BIT_RST = 7;
  localparam int BIT_HALT = 6;
  localparam int BIT_ERST = 5;
  localparam int BIT_CSTART = 4;
  localparam int BIT_SUPR = 3;
  localparam int BIT_INT_POL = 7;
  localparam int BIT_INT_OD = 6;
  localparam int BIT_READ_REF_CLOCK_OUT_EN = 4;
  localparam logic [7:0] HW_SET_CTL1 = 8'hE0;
  localparam logic [7:0] HW_SET_CFG3 = 8'hC0;
  localparam logic [7:0] HW_SET_PLL = 8'hE0;
  localparam logic [7:0] ERR_ZERO = 8'h00;
  localparam logic [7:0] IST0_KEEP = 8'h38;
  localparam logic [7:0] LIMIT_INIT = 8'h3F;
  localparam logic [7:0] GPO_INIT = 8'hF0;
  localparam logic [2:0] MODE_READ_ID = 3'h2;
  localparam logic [2:0] MODE_SEARCH_ID = 3'h3;
  localparam logic [2:0] MODE_FLAG_READ = 3'h4;
  localparam logic [2:0] MODE_FLAG_WRITE = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NSLOT = 12;
  localparam logic [3:0] SLOT_NONE = 4'hF;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BUSY = 2'b01, ST_RESET = 2'b11} erc_op_t;
endpackage

// ### core/erc_reset_ctrl.sv
// Purpose: Reset, halt, error reset and control register logic
// Assumes: Datapath requests arrive on mclk; pins pass two flip-flops
// Notes: Registers over AXI4-Lite, low byte of each word
// Operation
// - Hardware reset sets chip reset bit too
// - Hardware reset zeroes PLL strobes, stops clock
// - Hardware reset: interrupt active-low, open drain, idle
// - Hardware reset forces 10H, 12H, 2CH high bits
// - Software reset includes halt and error reset
// - Software reset drives all outputs inactive
// - Error reset halts, clears errors, self-clears
// - Error reset loads fixed register values
// - Halt aborts operation, drops both gates
// - Busy bit reads one until idle
// - Sector mark write disables windowing until mark
// - Preformat gate high until sector mark
// - Chip reset holds until zero is written
// - Bit 4 starts corrector, reads corrector busy
// - Bit 3 withholds correction vectors
// - Written registers read back
// - Nonzero transfer count starts an operation
// - Bits 2-0 select the operation mode
`timescale 1ns/1ps
module erc_reset_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [erc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [erc_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic hwResetN,
  input wire logic sectorMarkIn,
  input wire logic sectorDone,
  input wire logic correctorDone,
  input wire logic correctorVector,
  input wire logic intRequest,
  input wire logic [7:0] statusSet,
  input wire logic readGateReq,
  input wire logic writeGateReq,
  input wire logic [2:0] pllReq,
  input wire logic powerCalReq,
  input wire logic focusOffsetReq,
  input wire logic encodedWriteReq,
  input wire logic smPulseReq,
  input wire logic smFoundReq,
  input wire logic idFoundReq,
  input wire logic [7:0] nrzReq,
  input wire logic nrzDriveReq,
  output logic pllStrobeI,
  output logic pllStrobeM,
  output logic pllStrobeG,
  output logic readRefClockOut,
  output logic powerCalWindow,
  output logic focusOffsetWindow,
  output logic encodedWriteOut,
  output logic diskWriteGate,
  output logic diskReadGate,
  output logic preformatGate,
  output logic sectorMarkPulseT,
  output logic sectorMarkFound,
  output logic vectorOut,
  output logic idFound,
  output logic [7:0] nrzOut,
  output logic nrzOeN,
  output logic intOut,
  output logic intOeN,
  output logic smWindowEn,
  output logic flagGenEn,
  output logic opAbort,
  output logic errClear,
  output logic correctorStart
);
  import erc_pkg::*;

  if (ADDR_W < 10 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must be 10 to 32");
  end

  function automatic logic [3:0] slotOf(input logic [7:0] idx);
    case (idx)
      IDX_CFG3: slotOf = 4'h0;
      IDX_XFER: slotOf = 4'h1;
      IDX_IEN0: slotOf = 4'h2;
      IDX_IEN1: slotOf = 4'h3;
      IDX_IST0: slotOf = 4'h4;
      IDX_IST1: slotOf = 4'h5;
      IDX_LIMIT: slotOf = 4'h6;
      IDX_PLL: slotOf = 4'h7;
      IDX_LATCH0: slotOf = 4'h8;
      IDX_GPO: slotOf = 4'h9;
      IDX_LATCH1: slotOf = 4'hA;
      IDX_SMC: slotOf = 4'hB;
      default: slotOf = SLOT_NONE;
    endcase
  endfunction

  // Pin synchronisers
  logic hwSync1_r, hwSync2_r, smSync1_r, smSync2_r, smSync3_r;
  always_ff @(posedge mclk) begin
    if (reset) begin
      hwSync1_r <= 1'b0;
      hwSync2_r <= 1'b0;
      smSync1_r <= 1'b0;
      smSync2_r <= 1'b0;
      smSync3_r <= 1'b0;
    end else begin
      hwSync1_r <= hwResetN;
      hwSync2_r <= hwSync1_r;
      smSync1_r <= sectorMarkIn;
      smSync2_r <= smSync1_r;
      smSync3_r <= smSync2_r;
    end
  end

  logic awHave_r, awHave_nxt, wHave_r, wHave_nxt, awRdy_r, awRdy_nxt, wRdy_r, wRdy_nxt;
  logic [7:0] awIdx_r, awIdx_nxt, wByte_r, wByte_nxt;
  logic wLane_r, wLane_nxt, bVal_r, bVal_nxt, arRdy_r, arRdy_nxt, rVal_r, rVal_nxt;
  logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic chipRst_r, chipRst_nxt, corrBusy_r, corrBusy_nxt, smReset_r, smReset_nxt;
  logic [3:0] ctlLow_r, ctlLow_nxt;
  erc_op_t op_r, op_nxt;
  logic [7:0] regs_r [NSLOT];
  logic [7:0] regs_nxt [NSLOT];
  logic [2:0] pll_r, pll_nxt;
  logic read_ref_clock_out_r, read_ref_clock_out_nxt;
  logic [5:0] quiet_r, quiet_nxt;
  logic dwg_r, dwg_nxt, drg_r, drg_nxt, pref_r, pref_nxt, vec_r, vec_nxt;
  logic [7:0] nrz_r, nrz_nxt;
  logic nrzOeN_r, nrzOeN_nxt, intOut_r, intOut_nxt, intOeN_r, intOeN_nxt;
  logic smWin_r, smWin_nxt, flag_r, flag_nxt, abort_r, abort_nxt, errClr_r, errClr_nxt;
  logic cStart_r, cStart_nxt;
  logic hwRst, doWrite, wrHit, ctlWr, errRst, halt, startWr, smcWr;
  logic [3:0] wSlot, rSlot;
  logic [7:0] rIdx;
  logic intLvl;

  always_comb begin
    awHave_nxt = awHave_r;
    awIdx_nxt = awIdx_r;
    wHave_nxt = wHave_r;
    wByte_nxt = wByte_r;
    wLane_nxt = wLane_r;
    bVal_nxt = bVal_r;
    bResp_nxt = bResp_r;
    rVal_nxt = rVal_r;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    regs_nxt = regs_r;
    ctlLow_nxt = ctlLow_r;
    corrBusy_nxt = corrBusy_r;
    smReset_nxt = smReset_r;
    op_nxt = op_r;
    hwRst = !hwSync2_r;
    // Write channel capture, either order
    if (s_axi_awvalid && awRdy_r) begin
      awHave_nxt = 1'b1;
      awIdx_nxt = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && wRdy_r) begin
      wHave_nxt = 1'b1;
      wByte_nxt = s_axi_wdata[7:0];
      wLane_nxt = s_axi_wstrb[0];
    end
    if (bVal_r && s_axi_bready) begin
      bVal_nxt = 1'b0;
    end
    doWrite = awHave_r && wHave_r && !bVal_r;
    wSlot = slotOf(awIdx_r);
    if (doWrite) begin
      awHave_nxt = 1'b0;
      wHave_nxt = 1'b0;
      bVal_nxt = 1'b1;
      bResp_nxt = (wSlot != SLOT_NONE || awIdx_r == IDX_CTL1) ? RESP_OKAY : RESP_SLVERR;
    end
    wrHit = doWrite && wLane_r;
    ctlWr = wrHit && awIdx_r == IDX_CTL1;
    smcWr = wrHit && awIdx_r == IDX_SMC;
    // Chip reset bit
    chipRst_nxt = chipRst_r;
    if (hwRst) begin
      chipRst_nxt = 1'b1;
    end else if (ctlWr) begin
      chipRst_nxt = wByte_r[BIT_RST];
    end
    errRst = (ctlWr && wByte_r[BIT_ERST]) || (chipRst_nxt && !chipRst_r);
    halt = errRst || (ctlWr && wByte_r[BIT_HALT]);
    if (ctlWr) begin
      ctlLow_nxt = wByte_r[3:0];
    end
    if (wrHit && wSlot != SLOT_NONE) begin
      regs_nxt[wSlot] = wByte_r;
    end
    startWr = wrHit && awIdx_r == IDX_XFER && wByte_r != 8'h00 && !chipRst_nxt;
    if (errRst) begin
      regs_nxt[slotOf(IDX_IEN0)] = ERR_ZERO;
      regs_nxt[slotOf(IDX_IEN1)] = ERR_ZERO;
      regs_nxt[slotOf(IDX_IST1)] = ERR_ZERO;
      regs_nxt[slotOf(IDX_LATCH0)] = ERR_ZERO;
      regs_nxt[slotOf(IDX_LATCH1)] = ERR_ZERO;
      regs_nxt[slotOf(IDX_IST0)] = regs_r[slotOf(IDX_IST0)] & IST0_KEEP;
      regs_nxt[slotOf(IDX_LIMIT)] = LIMIT_INIT;
      regs_nxt[slotOf(IDX_GPO)] = GPO_INIT;
    end
    if (hwRst) begin
      regs_nxt[slotOf(IDX_CFG3)] = regs_nxt[slotOf(IDX_CFG3)] | HW_SET_CFG3;
      regs_nxt[slotOf(IDX_PLL)] = regs_nxt[slotOf(IDX_PLL)] | HW_SET_PLL;
    end
    // Status set wins over clear
    regs_nxt[slotOf(IDX_IST1)] = regs_nxt[slotOf(IDX_IST1)] | (statusSet & {8{!chipRst_nxt}});
    // Operation sequencing
    if (op_r == ST_BUSY && sectorDone) begin
      regs_nxt[slotOf(IDX_XFER)] = regs_r[slotOf(IDX_XFER)] - 8'h01;
      if (regs_r[slotOf(IDX_XFER)] <= 8'h01) begin
        op_nxt = ST_IDLE;
      end
    end
    case (op_r)
      ST_IDLE: if (startWr) op_nxt = ST_BUSY;
      ST_BUSY: if (halt) op_nxt = ST_IDLE;
      ST_RESET: op_nxt = ST_IDLE;
      default: op_nxt = ST_IDLE;
    endcase
    if (chipRst_nxt) begin
      op_nxt = ST_RESET;
    end
    // Corrector busy, start wins over done
    if (correctorDone || errRst) begin
      corrBusy_nxt = 1'b0;
    end
    if (ctlWr && wByte_r[BIT_CSTART] && !chipRst_nxt && !errRst) begin
      corrBusy_nxt = 1'b1;
    end
    // Sector mark reset, write wins over mark
    if (smSync2_r && !smSync3_r) begin
      smReset_nxt = 1'b0;
    end
    if (smcWr) begin
      smReset_nxt = 1'b1;
    end
    // Read channel
    rIdx = s_axi_araddr[9:2];
    rSlot = slotOf(rIdx);
    if (rVal_r && s_axi_rready) begin
      rVal_nxt = 1'b0;
    end
    if (s_axi_arvalid && arRdy_r) begin
      rVal_nxt = 1'b1;
      rResp_nxt = RESP_OKAY;
      rData_nxt = 32'h0000_0000;
      if (rIdx == IDX_CTL1) begin
        rData_nxt[7:0] = {chipRst_r, op_r == ST_BUSY, 1'b0, corrBusy_r, ctlLow_r};
      end else if (rSlot != SLOT_NONE) begin
        rData_nxt[7:0] = regs_r[rSlot];
      end else begin
        rResp_nxt = RESP_SLVERR;
      end
    end
    awRdy_nxt = !awHave_nxt && !bVal_nxt;
    wRdy_nxt = !wHave_nxt && !bVal_nxt;
    arRdy_nxt = !rVal_nxt;
    // Pins, all quiet while in chip reset
    for (int k = 0; k < 3; k++) begin
      pll_nxt[k] = (pllReq[k] && !chipRst_nxt) ~^ regs_nxt[slotOf(IDX_PLL)][5 + k];
    end
    read_ref_clock_out_nxt = !hwRst && !chipRst_nxt && regs_nxt[slotOf(IDX_PLL)][BIT_READ_REF_CLOCK_OUT_EN] && !read_ref_clock_out_r;
    quiet_nxt = {powerCalReq, focusOffsetReq, encodedWriteReq, smPulseReq, smFoundReq, idFoundReq}
      & {6{!chipRst_nxt}};
    drg_nxt = readGateReq && op_nxt == ST_BUSY;
    dwg_nxt = writeGateReq && op_nxt == ST_BUSY;
    pref_nxt = smReset_nxt && !chipRst_nxt;
    smWin_nxt = !smReset_nxt && !chipRst_nxt;
    vec_nxt = correctorVector && !ctlLow_nxt[BIT_SUPR] && !chipRst_nxt;
    nrz_nxt = nrzReq & {8{nrzDriveReq && !chipRst_nxt}};
    nrzOeN_nxt = !(nrzDriveReq && !chipRst_nxt);
    intLvl = (intRequest && !chipRst_nxt) ^ regs_nxt[slotOf(IDX_CFG3)][BIT_INT_POL];
    intOut_nxt = intLvl;
    intOeN_nxt = regs_nxt[slotOf(IDX_CFG3)][BIT_INT_OD] ? intLvl : 1'b0;
    flag_nxt = op_nxt == ST_BUSY
      && (ctlLow_nxt[2:0] == MODE_FLAG_READ || ctlLow_nxt[2:0] == MODE_FLAG_WRITE);
    abort_nxt = halt && op_r == ST_BUSY;
    errClr_nxt = errRst;
    cStart_nxt = ctlWr && wByte_r[BIT_CSTART] && !chipRst_nxt && !errRst;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      awHave_r <= 1'b0;
      awIdx_r <= 8'h00;
      wHave_r <= 1'b0;
      wByte_r <= 8'h00;
      wLane_r <= 1'b0;
      awRdy_r <= 1'b0;
      wRdy_r <= 1'b0;
      bVal_r <= 1'b0;
      bResp_r <= RESP_OKAY;
      arRdy_r <= 1'b0;
      rVal_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= RESP_OKAY;
      chipRst_r <= HW_SET_CTL1[BIT_RST];
      ctlLow_r <= 4'h0;
      corrBusy_r <= 1'b0;
      smReset_r <= 1'b0;
      op_r <= ST_RESET;
      for (int i = 0; i < NSLOT; i++) begin
        regs_r[i] <= 8'h00;
      end
      regs_r[slotOf(IDX_CFG3)] <= HW_SET_CFG3;
      regs_r[slotOf(IDX_PLL)] <= HW_SET_PLL;
      regs_r[slotOf(IDX_LIMIT)] <= LIMIT_INIT;
      regs_r[slotOf(IDX_GPO)] <= GPO_INIT;
      pll_r <= 3'h0;
      read_ref_clock_out_r <= 1'b0;
      quiet_r <= 6'h00;
      dwg_r <= 1'b0;
      drg_r <= 1'b0;
      pref_r <= 1'b0;
      vec_r <= 1'b0;
      nrz_r <= 8'h00;
      nrzOeN_r <= 1'b1;
      intOut_r <= 1'b1;
      intOeN_r <= 1'b1;
      smWin_r <= 1'b0;
      flag_r <= 1'b0;
      abort_r <= 1'b0;
      errClr_r <= 1'b0;
      cStart_r <= 1'b0;
    end else begin
      awHave_r <= awHave_nxt;
      awIdx_r <= awIdx_nxt;
      wHave_r <= wHave_nxt;
      wByte_r <= wByte_nxt;
      wLane_r <= wLane_nxt;
      awRdy_r <= awRdy_nxt;
      wRdy_r <= wRdy_nxt;
      bVal_r <= bVal_nxt;
      bResp_r <= bResp_nxt;
      arRdy_r <= arRdy_nxt;
      rVal_r <= rVal_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
      chipRst_r <= chipRst_nxt;
      ctlLow_r <= ctlLow_nxt;
      corrBusy_r <= corrBusy_nxt;
      smReset_r <= smReset_nxt;
      op_r <= op_nxt;
      regs_r <= regs_nxt;
      pll_r <= pll_nxt;
      read_ref_clock_out_r <= read_ref_clock_out_nxt;
      quiet_r <= quiet_nxt;
      dwg_r <= dwg_nxt;
      drg_r <= drg_nxt;
      pref_r <= pref_nxt;
      vec_r <= vec_nxt;
      nrz_r <= nrz_nxt;
      nrzOeN_r <= nrzOeN_nxt;
      intOut_r <= intOut_nxt;
      intOeN_r <= intOeN_nxt;
      smWin_r <= smWin_nxt;
      flag_r <= flag_nxt;
      abort_r <= abort_nxt;
      errClr_r <= errClr_nxt;
      cStart_r <= cStart_nxt;
    end
  end

  assign s_axi_awready = awRdy_r;
  assign s_axi_wready = wRdy_r;
  assign s_axi_bvalid = bVal_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arRdy_r;
  assign s_axi_rvalid = rVal_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign {pllStrobeG, pllStrobeM, pllStrobeI} = pll_r;
  assign readRefClockOut = read_ref_clock_out_r;
  assign {powerCalWindow, focusOffsetWindow, encodedWriteOut} = quiet_r[5:3];
  assign {sectorMarkPulseT, sectorMarkFound, idFound} = quiet_r[2:0];
  assign diskWriteGate = dwg_r;
  assign diskReadGate = drg_r;
  assign preformatGate = pref_r;
  assign vectorOut = vec_r;
  assign nrzOut = nrz_r;
  assign nrzOeN = nrzOeN_r;
  assign intOut = intOut_r;
  assign intOeN = intOeN_r;
  assign smWindowEn = smWin_r;
  assign flagGenEn = flag_r;
  assign opAbort = abort_r;
  assign errClear = errClr_r;
  assign correctorStart = cStart_r;

  AST_HW_SETS_RST: assert property (@(posedge mclk) disable iff (reset)
    hwRst |=> chipRst_r) else $error("hw reset did not set chip reset");
  AST_PLL_ZERO: assert property (@(posedge mclk) disable iff (reset)
    hwRst ##1 hwRst |=> pll_r == 3'h0 && !read_ref_clock_out_r) else $error("pll strobes active in hw reset");
  AST_INT_IDLE: assert property (@(posedge mclk) disable iff (reset)
    hwRst ##1 hwRst |=> intOut && intOeN) else $error("interrupt not idle in hw reset");
  AST_HW_BITS: assert property (@(posedge mclk) disable iff (reset)
    hwRst |=> regs_r[0][7:6] == 2'b11 && regs_r[7][7:5] == 3'b111) else $error("hw bits not set");
  AST_QUIET: assert property (@(posedge mclk) disable iff (reset)
    chipRst_r ##1 chipRst_r |-> !dwg_r && !drg_r && !pref_r && !vec_r && quiet_r == 6'h00 && nrzOeN_r)
    else $error("output active in chip reset");
  AST_ERR_LOAD: assert property (@(posedge mclk) disable iff (reset)
    errRst && !hwRst |=> regs_r[6] == 8'h3F && regs_r[9] == 8'hF0 && regs_r[2] == 8'h00 && errClr_r)
    else $error("error reset values wrong");
  AST_HALT: assert property (@(posedge mclk) disable iff (reset)
    ctlWr && wByte_r[BIT_HALT] |=> op_r != ST_BUSY && !dwg_r && !drg_r) else $error("halt failed");
  AST_BUSY_BIT: assert property (@(posedge mclk) disable iff (reset)
    rVal_r && $past(s_axi_arvalid && arRdy_r && s_axi_araddr[9:2] == IDX_CTL1)
    |-> rData_r[6] == ($past(op_r) == ST_BUSY)) else $error("busy bit wrong");
  AST_SM_RESET: assert property (@(posedge mclk) disable iff (reset)
    smcWr && !chipRst_nxt |=> pref_r && !smWin_r) else $error("sector mark reset failed");
  AST_VEC: assert property (@(posedge mclk) disable iff (reset)
    vec_r |-> !ctlLow_r[BIT_SUPR]) else $error("vector sent while suppressed");
  AST_CORR: assert property (@(posedge mclk) disable iff (reset)
    cStart_nxt |=> corrBusy_r && cStart_r) else $error("corrector start failed");
  AST_START: assert property (@(posedge mclk) disable iff (reset)
    startWr && op_r == ST_IDLE |=> op_r == ST_BUSY) else $error("operation did not start");
  AST_SYNC: assert property (@(posedge mclk) disable iff (reset)
    !hwResetN ##1 !hwResetN ##1 !hwResetN |=> chipRst_r) else $error("pin reset not seen");
endmodule

// ### verification/erc_mcu_model.sv
// Purpose: Local controller model, register bus master
// Assumes: One write or one read at a time
// Notes: Released address and data lines carry inverted values
`timescale 1ns/1ps
module erc_mcu_model #(
  parameter int ADDR_W = 12
) (
  input wire logic mclk,
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  logic [1:0] lastBresp = 2'h0;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Write, address and data offered together
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge mclk);
    awaddr <= ADDR_W'({idx, 2'b00});
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
    end while (!(bvalid && bready));
    lastBresp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge mclk);
    araddr <= ADDR_W'({idx, 2'b00});
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~araddr;
      end
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask
endmodule

// ### verification/erc_reset_ctrl_bench.sv
// Purpose: Self-checking bench for the reset and control block
// Assumes: Byte address is four times the register index
// Notes: Reads are compared by a monitor against queued notes
`timescale 1ns/1ps
module erc_reset_ctrl_bench;
  import erc_pkg::*;
  localparam logic [7:0] IDXT [8] = '{IDX_IEN0, IDX_IEN1, IDX_IST0, IDX_IST1, IDX_LIMIT,
    IDX_LATCH0, IDX_GPO, IDX_LATCH1};
  localparam logic [7:0] KEEPT [8] = '{8'h00, 8'h00, IST0_KEEP, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] POSTT [8] = '{8'h00, 8'h00, 8'h00, 8'h00, LIMIT_INIT, 8'h00, GPO_INIT,
    8'h00};
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hwResetN = 1'b1;
  logic sectorMarkIn = 1'b0;
  logic sectorDone = 1'b0;
  logic correctorDone = 1'b0;
  logic correctorVector = 1'b1;
  logic intRequest = 1'b1;
  logic readGateReq = 1'b1;
  logic writeGateReq = 1'b1;
  logic [2:0] pllReq = 3'h7;
  logic [5:0] lvReq = 6'h3F;
  logic [7:0] nrzReq = 8'hA5;
  logic nrzDriveReq = 1'b1;
  logic [7:0] rnd = 8'h45;
  logic [7:0] stSet = 8'h00;
  logic [7:0] nAbort = 8'h00, nErr = 8'h00, nStart = 8'h00;
  logic rrSeen;
  logic [7:0] wv [8];
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic pllI, pllM, pllG, read_ref_clock_out, pcw, fow, ewo, wrGate, rdGate, preGate, smp, smf, vec, idOut;
  logic [7:0] nrzOut;
  logic nrzOeN, intOut, intOeN, smWindowEn, flagGenEn, opAbort, errClear, correctorStart;
  logic [33:0] expQ [$];
  logic [33:0] mskQ [$];
  int bad_count = 0;
  int checked = 0;
  always #2 mclk = ~mclk;
  erc_reset_ctrl erc_reset_ctrl_inst (.mclk(mclk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hwResetN(hwResetN), .sectorMarkIn(sectorMarkIn), .sectorDone(sectorDone),
    .correctorDone(correctorDone), .correctorVector(correctorVector), .intRequest(intRequest),
    .statusSet(stSet), .readGateReq(readGateReq), .writeGateReq(writeGateReq), .pllReq(pllReq),
    .powerCalReq(lvReq[0]), .focusOffsetReq(lvReq[1]), .encodedWriteReq(lvReq[2]),
    .smPulseReq(lvReq[3]), .smFoundReq(lvReq[4]), .idFoundReq(lvReq[5]), .nrzReq(nrzReq),
    .nrzDriveReq(nrzDriveReq), .pllStrobeI(pllI), .pllStrobeM(pllM), .pllStrobeG(pllG),
    .readRefClockOut(read_ref_clock_out), .powerCalWindow(pcw), .focusOffsetWindow(fow),
    .encodedWriteOut(ewo), .diskWriteGate(wrGate), .diskReadGate(rdGate), .preformatGate(preGate),
    .sectorMarkPulseT(smp), .sectorMarkFound(smf), .vectorOut(vec), .idFound(idOut),
    .nrzOut(nrzOut), .nrzOeN(nrzOeN), .intOut(intOut), .intOeN(intOeN), .smWindowEn(smWindowEn),
    .flagGenEn(flagGenEn), .opAbort(opAbort), .errClear(errClear),
    .correctorStart(correctorStart));
  erc_mcu_model mcu_inst (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [7:0] m,
    input logic [1:0] r);
    expQ.push_back({r, 24'h0, e});
    mskQ.push_back({2'b11, 24'hFFFFFF, m});
    mcu_inst.rd(idx);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic end_sim;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Monitor takes the oldest note at each read answer
  always @(posedge mclk) begin
    if (rvalid && rready) begin
      chk("read", {rresp, rdata} & mskQ.pop_front(), expQ.pop_front());
    end
  end
  // Pulse outputs counted while they stand
  always @(posedge mclk) begin
    if (opAbort) nAbort <= nAbort + 8'h01;
    if (errClear) nErr <= nErr + 8'h01;
    if (correctorStart) nStart <= nStart + 8'h01;
  end
  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    tick(3);
    chk("held outputs", {pllI, pllM, pllG, pcw, fow, ewo, smp, smf, vec, idOut, rdGate, wrGate,
      read_ref_clock_out, nrzOut}, '0);
    chk("pins in reset", {nrzOeN, intOut, intOeN}, 3'b111);
    rd(IDX_CTL1, 8'h80, 8'h80, RESP_OKAY);
    rd(IDX_CFG3, HW_SET_CFG3, 8'hFF, RESP_OKAY);
    rd(IDX_PLL, HW_SET_PLL, 8'hFF, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wv[i] = rnd;
      mcu_inst.wr(IDXT[i], rnd);
      rd(IDXT[i], rnd, 8'hFF, RESP_OKAY);
    end
    mcu_inst.wr(IDX_CTL1, 8'h20);
    for (int i = 0; i < 8; i++) begin
      rd(IDXT[i], (wv[i] & KEEPT[i]) | POSTT[i], 8'hFF, RESP_OKAY);
    end
    rd(IDX_CTL1, 8'h00, 8'hA0, RESP_OKAY);
    @(posedge mclk);
    rnd = lfsr(rnd);
    nrzReq <= rnd;
    pllReq <= rnd[2:0];
    tick(2);
    chk("released", {pcw, fow, ewo, smp, smf, idOut, vec, nrzOeN, intOeN, intOut},
      10'b1111111000);
    chk("pll positive", {pllG, pllM, pllI, nrzOut}, {rnd[2:0], rnd});
    mcu_inst.wr(IDX_CTL1, 8'h08);
    tick(2);
    chk("vector held", vec, 1'b0);
    rd(IDX_CTL1, 8'h08, 8'h08, RESP_OKAY);
    mcu_inst.wr(IDX_CTL1, 8'h10);
    rd(IDX_CTL1, 8'h10, 8'h10, RESP_OKAY);
    @(posedge mclk);
    correctorDone <= 1'b1;
    @(posedge mclk);
    correctorDone <= 1'b0;
    tick(2);
    rd(IDX_CTL1, 8'h00, 8'h10, RESP_OKAY);
    for (int m = 2; m < 6; m++) begin
      mcu_inst.wr(IDX_CTL1, 8'(m));
      mcu_inst.wr(IDX_XFER, 8'h01);
      tick(2);
      chk("busy pins", {flagGenEn, rdGate, wrGate}, {m > 3, 2'b11});
      rd(IDX_CTL1, 8'h40 | 8'(m), 8'hFF, RESP_OKAY);
      if (m == 2) begin
        @(posedge mclk);
        sectorDone <= 1'b1;
        @(posedge mclk);
        sectorDone <= 1'b0;
      end else begin
        mcu_inst.wr(IDX_CTL1, 8'h40 | 8'(m));
      end
      tick(2);
      chk("idle pins", {flagGenEn, rdGate, wrGate}, 3'b000);
      rd(IDX_CTL1, 8'h00, 8'h40, RESP_OKAY);
    end
    mcu_inst.wr(IDX_SMC, 8'h01);
    tick(2);
    chk("mark reset", {preGate, smWindowEn}, 2'b10);
    @(posedge mclk);
    sectorMarkIn <= 1'b1;
    for (int i = 0; i < 20 && preGate !== 1'b0; i++) tick(1);
    chk("mark seen", {preGate, smWindowEn}, 2'b01);
    @(posedge mclk);
    sectorMarkIn <= 1'b0;
    stSet <= 8'h81;
    @(posedge mclk);
    stSet <= 8'h00;
    rd(IDX_IST1, 8'h81, 8'hFF, RESP_OKAY);
    rd(8'h05, 8'h00, 8'hFF, RESP_SLVERR);
    mcu_inst.wr(8'h05, 8'hFF);
    chk("unmapped write", mcu_inst.lastBresp, RESP_SLVERR);
    mcu_inst.wr(IDX_PLL, 8'h10);
    mcu_inst.wr(IDX_CFG3, 8'h00);
    mcu_inst.wr(IDX_LIMIT, 8'h00);
    tick(2);
    chk("pll negative", {pllG, pllM, pllI}, 3'(~rnd[2:0]));
    chk("int push-pull", {intOut, intOeN}, 2'b10);
    rrSeen = read_ref_clock_out;
    tick(1);
    chk("ref clock runs", read_ref_clock_out, !rrSeen);
    @(posedge mclk);
    hwResetN <= 1'b0;
    tick(4);
    @(posedge mclk);
    hwResetN <= 1'b1;
    tick(4);
    chk("pins after pin reset", {pllG, pllM, pllI, read_ref_clock_out, intOut, intOeN}, 6'b000011);
    rd(IDX_CTL1, 8'h80, 8'h80, RESP_OKAY);
    rd(IDX_PLL, HW_SET_PLL, HW_SET_PLL, RESP_OKAY);
    rd(IDX_CFG3, HW_SET_CFG3, HW_SET_CFG3, RESP_OKAY);
    rd(IDX_LIMIT, LIMIT_INIT, 8'hFF, RESP_OKAY);
    rd(IDX_IST1, 8'h00, 8'hFF, RESP_OKAY);
    tick(4);
    chk("pulses", {nAbort, nErr, nStart}, {8'h03, 8'h02, 8'h01});
    end_sim();
  end
endmodule
